// file: logic/sir_defines.vh
// Register offsets, field positions and reset values for the status register group
`ifndef SIR_DEFINES_VH
`define SIR_DEFINES_VH
`define SIR_ADDR_PART 7'h00
`define SIR_ADDR_REV 7'h01
`define SIR_ADDR_COND 7'h02
`define SIR_ADDR_EVT1 7'h03
`define SIR_ADDR_ENA1 7'h05
`define SIR_ADDR_RXTHR 7'h7e
`define SIR_RXTHR_RESET 6'h37
// Arbitrary identity values
`define SIR_PART_KIND 5'h15
`define SIR_REV_VALUE 5'h0a
`define SIR_COND_OVFL 7
`define SIR_COND_UNFL 6
`define SIR_COND_RXEM 5
`define SIR_COND_HDRE 4
`define SIR_COND_FRQE 3
`define SIR_COND_LOCK 2
`define SIR_PS_IDLE 2'h0
`define SIR_PS_RX 2'h1
`define SIR_PS_TX 2'h2
`define SIR_EV_FERR 7
`define SIR_EV_TXAF 6
`define SIR_EV_TXAE 5
`define SIR_EV_RXAF 4
`define SIR_EV_EXT 3
`define SIR_EV_SENT 2
`define SIR_EV_VALID 1
`define SIR_EV_CRC 0
`endif

// file: logic/sir_sync.v
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sir_sync #(
   parameter W = 8
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // sir_sync
`default_nettype wire

// file: logic/sir_flags.v
// Event flag bank: sticky set, read clear of enabled bits, set wins
`timescale 1ns/1ps
`default_nettype none
module sir_flags (
   input wire clk,
   input wire rst_n,
   input wire [7:0] set_ev,
   input wire [7:0] hw_clr,
   input wire [7:0] enable,
   input wire rd_clr,
   output reg [7:0] flags
);
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               flags[i] <= 1'b0;
            end else if (set_ev[i]) begin
               flags[i] <= 1'b1;
            end else if (hw_clr[i] || (rd_clr && enable[i])) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule // sir_flags
`default_nettype wire

// file: logic/sir_status_regs.v
// Identification, device status and interrupt/status 1 register group
`include "sir_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: Part kind code in bits 4:0, upper zero
// RL2: Revision field in bits 4:0, upper zero
// RL3: Status bits 7..5 overflow, underflow, RX empty
// RL4: Status bit 4 header check error
// RL5: Status bit 3 frequency out of range, clamped
// RL6: Status bit 2 synthesizer lock
// RL7: Status bits 1:0 power state code
// RL8: Event bit 7 any FIFO error
// RL9: Event bit 6 TX FIFO almost full
// RL10: Event bit 5 TX FIFO almost empty
// RL11: Event bit 4 RX FIFO almost full
// RL12: Event bit 3 pin event source
// RL13: Event bit 2 packet sent
// RL14: Event bit 1 valid packet received
// RL15: Event bit 0 CRC failure
// RL16: Enabled rising event pulls interrupt low
// RL17: Event register read releases line, clears enabled
// RL18: Disabled bits are plain status, not cleared
// RL19: FIFO error clears only on FIFO reset; a read also clears it when bit 7 is enabled
// RL20: Sent flag clears leaving FIFO mode, new send
// RL21: Host reads event register after interrupt
module sir_status_regs (
   // Clock and reset
   input wire SYS_CLK,
   input wire RST_N,
   // Register access
   input wire REG_RD,
   input wire REG_WR,
   input wire [6:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   // Pin-side conditions, asynchronous
   input wire FIFO_OVFL,
   input wire FIFO_UNFL,
   input wire RX_FIFO_EMPTY,
   input wire HEADER_ERR,
   input wire SYNTH_LOCK,
   input wire [1:0] POWER_STATE,
   input wire EXT_PIN_EVENT,
   // Datapath events, same clock
   input wire TX_FIFO_ERR,
   input wire RX_FIFO_ERR,
   input wire TX_FIFO_RESET,
   input wire RX_FIFO_RESET,
   input wire TX_ALMOST_FULL,
   input wire TX_ALMOST_EMPTY,
   input wire [6:0] RX_FIFO_LEVEL,
   input wire PKT_SENT,
   input wire TX_START,
   input wire FIFO_MODE,
   input wire PKT_VALID,
   input wire SYNC_ACK,
   input wire CRC_FAIL,
   input wire RX_START,
   // Frequency control
   input wire [15:0] FREQ_REQ,
   input wire [15:0] FREQ_MIN,
   input wire [15:0] FREQ_MAX,
   output reg [15:0] FREQ_ACT,
   // Configuration and interrupt
   output reg [5:0] RX_AF_THRESH,
   output reg IRQ_OUT_N
);
   wire [6:0] pin_sync;
   reg [7:0] ena_reg;
   reg [5:0] rxthr_reg;
   reg [7:0] ev_prev_reg;
   reg tx_err_reg;
   reg rx_err_reg;
   reg fifo_mode_reg;
   reg ext_prev_reg;
   reg freq_err_reg;
   wire ext_sync;
   wire irq_rise;
   wire [7:0] flags;
   reg [7:0] set_ev;
   reg [7:0] hw_clr;
   reg [7:0] cond_next;
   reg [7:0] rdata_next;
   wire rd_evt;
   wire rx_af;
   wire freq_lo;
   wire freq_hi;

   sir_sync #(.W(7)) u_sync (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .d({FIFO_OVFL, FIFO_UNFL, RX_FIFO_EMPTY, HEADER_ERR, SYNTH_LOCK, POWER_STATE}),
      .q(pin_sync)
   );

   // Pin event source gets its own two flops before edge detection
   sir_sync #(.W(1)) u_sync_ext (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .d(EXT_PIN_EVENT),
      .q(ext_sync)
   );

   assign rd_evt = REG_RD && (REG_ADDR == `SIR_ADDR_EVT1);
   assign rx_af = ({1'b0, RX_FIFO_LEVEL} > {2'b00, rxthr_reg}); // RL11
   assign freq_lo = (FREQ_REQ < FREQ_MIN);
   assign freq_hi = (FREQ_REQ > FREQ_MAX);
   assign irq_rise = |(flags & ~ev_prev_reg & ena_reg); // RL16

   // Writable registers
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ena_reg <= 8'h00;
         rxthr_reg <= `SIR_RXTHR_RESET;
      end else if (REG_WR) begin
         if (REG_ADDR == `SIR_ADDR_ENA1) begin
            ena_reg <= REG_WDATA;
         end else if (REG_ADDR == `SIR_ADDR_RXTHR) begin
            rxthr_reg <= REG_WDATA[5:0];
         end
      end
   end

   // Sticky FIFO error per FIFO, cleared only by that FIFO's reset
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_err_reg <= 1'b0;
         rx_err_reg <= 1'b0;
      end else begin
         if (TX_FIFO_ERR) begin
            tx_err_reg <= 1'b1;
         end else if (TX_FIFO_RESET) begin
            tx_err_reg <= 1'b0; // RL19
         end
         if (RX_FIFO_ERR) begin
            rx_err_reg <= 1'b1;
         end else if (RX_FIFO_RESET) begin
            rx_err_reg <= 1'b0; // RL19
         end
      end
   end

   // Event sources and hardware clears
   always @* begin
      set_ev = 8'h00;
      hw_clr = 8'h00;
      set_ev[`SIR_EV_FERR] = TX_FIFO_ERR || RX_FIFO_ERR; // RL8
      hw_clr[`SIR_EV_FERR] = (TX_FIFO_RESET || !tx_err_reg) && (RX_FIFO_RESET || !rx_err_reg)
         && (TX_FIFO_RESET || RX_FIFO_RESET); // RL19
      set_ev[`SIR_EV_TXAF] = TX_ALMOST_FULL; // RL9
      hw_clr[`SIR_EV_TXAF] = !TX_ALMOST_FULL && !ena_reg[`SIR_EV_TXAF];
      set_ev[`SIR_EV_TXAE] = TX_ALMOST_EMPTY; // RL10
      hw_clr[`SIR_EV_TXAE] = !TX_ALMOST_EMPTY && !ena_reg[`SIR_EV_TXAE];
      set_ev[`SIR_EV_RXAF] = rx_af; // RL11
      hw_clr[`SIR_EV_RXAF] = !rx_af && !ena_reg[`SIR_EV_RXAF];
      set_ev[`SIR_EV_EXT] = ext_sync && !ext_prev_reg; // RL12
      set_ev[`SIR_EV_SENT] = PKT_SENT; // RL13
      hw_clr[`SIR_EV_SENT] = (fifo_mode_reg && !FIFO_MODE) || (FIFO_MODE && TX_START); // RL20
      set_ev[`SIR_EV_VALID] = PKT_VALID; // RL14
      hw_clr[`SIR_EV_VALID] = SYNC_ACK;
      set_ev[`SIR_EV_CRC] = CRC_FAIL; // RL15
      hw_clr[`SIR_EV_CRC] = RX_START;
   end

   // Read clears only enabled bits; disabled ones stay as status
   sir_flags u_flags (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .set_ev(set_ev),
      .hw_clr(hw_clr),
      .enable(ena_reg),
      .rd_clr(rd_evt), // RL17 RL18
      .flags(flags)
   );

   // Device condition byte
   always @* begin
      cond_next = 8'h00;
      cond_next[`SIR_COND_OVFL] = pin_sync[6]; // RL3
      cond_next[`SIR_COND_UNFL] = pin_sync[5]; // RL3
      cond_next[`SIR_COND_RXEM] = pin_sync[4]; // RL3
      cond_next[`SIR_COND_HDRE] = pin_sync[3]; // RL4
      cond_next[`SIR_COND_FRQE] = freq_err_reg; // RL5
      cond_next[`SIR_COND_LOCK] = pin_sync[2]; // RL6
      cond_next[1:0] = pin_sync[1:0]; // RL7
   end

   // Read data mux
   always @* begin
      rdata_next = 8'h00;
      if (REG_ADDR == `SIR_ADDR_PART) begin
         rdata_next = {3'b000, `SIR_PART_KIND}; // RL1
      end else if (REG_ADDR == `SIR_ADDR_REV) begin
         rdata_next = {3'b000, `SIR_REV_VALUE}; // RL2
      end else if (REG_ADDR == `SIR_ADDR_COND) begin
         rdata_next = cond_next;
      end else if (REG_ADDR == `SIR_ADDR_EVT1) begin
         rdata_next = flags;
      end else if (REG_ADDR == `SIR_ADDR_ENA1) begin
         rdata_next = ena_reg;
      end else if (REG_ADDR == `SIR_ADDR_RXTHR) begin
         rdata_next = {2'b00, rxthr_reg};
      end
   end

   // Read data register, held until the next read
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= rdata_next;
      end
   end

   // Edge history of flags, mode and pin event
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ev_prev_reg <= 8'h00;
         fifo_mode_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         ev_prev_reg <= flags;
         fifo_mode_reg <= FIFO_MODE;
         ext_prev_reg <= ext_sync;
      end
   end

   // Frequency clamp and range error
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         freq_err_reg <= 1'b0;
         FREQ_ACT <= 16'h0000;
      end else begin
         freq_err_reg <= freq_lo || freq_hi; // RL5
         if (freq_lo) begin
            FREQ_ACT <= FREQ_MIN; // RL5
         end else if (freq_hi) begin
            FREQ_ACT <= FREQ_MAX; // RL5
         end else begin
            FREQ_ACT <= FREQ_REQ;
         end
      end
   end

   // Threshold copy for the receive FIFO logic
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RX_AF_THRESH <= `SIR_RXTHR_RESET;
      end else begin
         RX_AF_THRESH <= rxthr_reg;
      end
   end

   // Interrupt line; a read that already shows a fresh rise releases it,
   // otherwise the line would stay low with no pending bit left
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ_OUT_N <= 1'b1;
      end else if (irq_rise && !rd_evt) begin
         IRQ_OUT_N <= 1'b0; // RL16
      end else if (rd_evt) begin
         IRQ_OUT_N <= 1'b1; // RL17
      end
   end
endmodule // sir_status_regs
`default_nettype wire

// file: bench/sir_chk.sv
// Assertion checker for the status register group
`timescale 1ns/1ps
`default_nettype none
`include "sir_defines.vh"
module sir_chk (
   // Watched ports
   input wire logic SYS_CLK, RST_N, REG_RD, REG_WR, FIFO_OVFL, FIFO_UNFL, RX_FIFO_EMPTY, HEADER_ERR,
   input wire logic SYNTH_LOCK, PKT_VALID, CRC_FAIL, PKT_SENT, TX_FIFO_ERR, RX_FIFO_ERR, EXT_PIN_EVENT,
   input wire logic TX_ALMOST_FULL, TX_ALMOST_EMPTY, IRQ_OUT_N,
   input wire logic [1:0] POWER_STATE,
   input wire logic [5:0] RX_AF_THRESH,
   input wire logic [6:0] REG_ADDR, RX_FIFO_LEVEL,
   input wire logic [7:0] REG_WDATA, REG_RDATA,
   input wire logic [15:0] FREQ_REQ, FREQ_MIN, FREQ_MAX, FREQ_ACT
);
   logic [7:0] ena_reg;
   logic [6:0] cond_reg;
   logic [1:0] same_reg;
   wire [6:0] cond = {FIFO_OVFL, FIFO_UNFL, RX_FIFO_EMPTY, HEADER_ERR, SYNTH_LOCK, POWER_STATE};
   wire above = RX_FIFO_LEVEL > {1'b0, RX_AF_THRESH};
   wire ev = PKT_VALID | CRC_FAIL | PKT_SENT | TX_FIFO_ERR | RX_FIFO_ERR | EXT_PIN_EVENT |
      TX_ALMOST_FULL | TX_ALMOST_EMPTY | above;
   wire rd3 = REG_RD && REG_ADDR == 7'h03;
   // Shadow of the enable register and a stability count of the conditions
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ena_reg <= 8'h00;
         cond_reg <= 7'h00;
         same_reg <= 2'h0;
      end else begin
         if (REG_WR && REG_ADDR == 7'h05) ena_reg <= REG_WDATA;
         cond_reg <= cond;
         same_reg <= (cond != cond_reg) ? 2'h0 : (same_reg == 2'h3) ? 2'h3 : same_reg + 2'h1;
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   AST_PART: assert property (REG_RD && REG_ADDR == 7'h00 |=> REG_RDATA == {3'h0, `SIR_PART_KIND})
      else $error("part kind read wrong");
   AST_REV: assert property (REG_RD && REG_ADDR == 7'h01 |=> REG_RDATA == {3'h0, `SIR_REV_VALUE})
      else $error("revision read wrong");
   AST_COND: assert property (REG_RD && REG_ADDR == 7'h02 && same_reg == 2'h3 && cond == cond_reg |=>
      {REG_RDATA[7:4], REG_RDATA[2:0]} == $past(cond)) else $error("condition read wrong");
   AST_FHI: assert property (FREQ_REQ > FREQ_MAX |=> FREQ_ACT == $past(FREQ_MAX))
      else $error("frequency not clamped high");
   AST_FLO: assert property (FREQ_REQ < FREQ_MIN |=> FREQ_ACT == $past(FREQ_MIN))
      else $error("frequency not clamped low");
   AST_IRQL: assert property (PKT_VALID && ena_reg[1] ##1 !REG_RD |=> !IRQ_OUT_N)
      else $error("interrupt not raised");
   AST_IRQH: assert property (rd3 && !ev && !$past(ev) |=> IRQ_OUT_N)
      else $error("interrupt not released");
   AST_RXAF: assert property (rd3 && above && $past(above) |=> REG_RDATA[4])
      else $error("receive almost full missing");
   cover property ($fell(IRQ_OUT_N));
   cover property (rd3 ##1 REG_RDATA[7]);
   cover property (FREQ_REQ > FREQ_MAX);
endmodule // sir_chk
bind sir_status_regs sir_chk sir_chk_inst (.*);
`default_nettype wire

// file: bench/sir_host.sv
// Host model driving register strobes
`timescale 1ns/1ps
`default_nettype none
module sir_host (
   // Register access
   input wire logic SYS_CLK,
   output var logic REG_RD, REG_WR,
   output var logic [6:0] REG_ADDR,
   output var logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA
);
   initial begin
      REG_RD = 1'b0;
      REG_WR = 1'b0;
      REG_ADDR = 7'h7f;
      REG_WDATA = 8'hff;
   end
   // One strobe cycle; idle bus shows inverted values
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge SYS_CLK);
      #1;
      REG_RD = !wr;
      REG_WR = wr;
      REG_ADDR = a;
      REG_WDATA = d;
      @(posedge SYS_CLK);
      #1;
      REG_RD = 1'b0;
      REG_WR = 1'b0;
      REG_ADDR = ~a;
      REG_WDATA = ~d;
      q = REG_RDATA;
   endtask
endmodule // sir_host
`default_nettype wire

// file: bench/tb.sv
// Self-checking testbench for the status register group
`timescale 1ns/1ps
`default_nettype none
`include "sir_defines.vh"
module tb;
   logic SYS_CLK, RST_N, REG_RD, REG_WR, FIFO_OVFL, FIFO_UNFL, RX_FIFO_EMPTY, HEADER_ERR, SYNTH_LOCK;
   logic EXT_PIN_EVENT, TX_FIFO_ERR, RX_FIFO_ERR, TX_FIFO_RESET, RX_FIFO_RESET, TX_ALMOST_FULL, TX_ALMOST_EMPTY;
   logic PKT_SENT, TX_START, FIFO_MODE, PKT_VALID, SYNC_ACK, CRC_FAIL, RX_START, IRQ_OUT_N;
   logic [1:0] POWER_STATE;
   logic [5:0] RX_AF_THRESH;
   logic [6:0] REG_ADDR, RX_FIFO_LEVEL;
   logic [7:0] REG_WDATA, REG_RDATA, q;
   logic [15:0] FREQ_REQ, FREQ_MIN, FREQ_MAX, FREQ_ACT;
   logic [4:0] pat [3] = '{5'h15, 5'h0a, 5'h1f};
   int n_mismatch = 0;
   int check_count = 0;
   sir_status_regs sir_status_regs_inst (.*);
   sir_host sir_host_inst (.*);
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rd(input logic [6:0] a);
      sir_host_inst.xfer(1'b0, a, 8'h00, q);
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      clk(1);
      s = 1'b0;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      SYS_CLK = 1'b0;
      forever #50 SYS_CLK = ~SYS_CLK;
   end
   initial begin
      #1000000;
      n_mismatch++;
      summarize;
   end
   initial begin
      {RST_N, FIFO_OVFL, FIFO_UNFL, RX_FIFO_EMPTY, HEADER_ERR, SYNTH_LOCK, EXT_PIN_EVENT, TX_FIFO_ERR} = '0;
      {RX_FIFO_ERR, TX_FIFO_RESET, RX_FIFO_RESET, TX_ALMOST_FULL, TX_ALMOST_EMPTY, PKT_SENT} = '0;
      {TX_START, PKT_VALID, SYNC_ACK, CRC_FAIL, RX_START, POWER_STATE, RX_FIFO_LEVEL} = '0;
      FIFO_MODE = 1'b1;
      {FREQ_REQ, FREQ_MIN, FREQ_MAX} = {16'h0100, 16'h0010, 16'h1000};
      clk(3);
      RST_N = 1'b1;
      sir_host_inst.xfer(1'b1, 7'h00, 8'hff, q);
      rd(7'h00);
      chk("part", {3'h0, `SIR_PART_KIND}, q);
      rd(7'h01);
      chk("rev", {3'h0, `SIR_REV_VALUE}, q);
      rd(7'h40);
      chk("unmapped", 8'h00, q);
      rd(7'h7e);
      chk("thr", 8'h37, q);
      sir_host_inst.xfer(1'b1, 7'h7e, 8'h05, q);
      rd(7'h7e);
      chk("thr", 8'h05, q);
      chk("thrpin", 8'h05, RX_AF_THRESH);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         {FIFO_OVFL, FIFO_UNFL, RX_FIFO_EMPTY, HEADER_ERR, SYNTH_LOCK} = pat[i];
         POWER_STATE = i[1:0];
         clk(5);
         rd(7'h02);
         chk("cond", {pat[i][4:1], 1'b0, pat[i][0], i[1:0]}, q);
      end
      FREQ_REQ = 16'hf000;
      clk(5);
      chk("freq", FREQ_MAX, FREQ_ACT);
      rd(7'h02);
      chk("freqerr", 1'b1, q[3]);
      FREQ_REQ = 16'h0001;
      clk(2);
      chk("freq", FREQ_MIN, FREQ_ACT);
      $display("test status done");
      sir_host_inst.xfer(1'b1, 7'h05, 8'h0b, q);
      rd(7'h05);
      chk("ena", 8'h0b, q);
      for (int i = 0; i < 3; i++) begin
         case (i)
            0: pulse(CRC_FAIL);
            1: pulse(PKT_VALID);
            default: pulse(EXT_PIN_EVENT);
         endcase
         clk(4);
         chk("irq", 1'b0, IRQ_OUT_N);
         rd(7'h03);
         chk("evt", 8'h01 << (i == 2 ? 3 : i), q);
         chk("irq", 1'b1, IRQ_OUT_N);
         rd(7'h03);
         chk("evt", 8'h00, q);
      end
      pulse(PKT_SENT);
      clk(2);
      chk("irq", 1'b1, IRQ_OUT_N);
      repeat (2) begin
         rd(7'h03);
         chk("evt", 8'h04, q);
      end
      pulse(RX_FIFO_ERR);
      pulse(TX_FIFO_RESET);
      rd(7'h03);
      chk("evt", 8'h84, q);
      pulse(RX_FIFO_RESET);
      rd(7'h03);
      chk("evt", 8'h04, q);
      {TX_ALMOST_FULL, TX_ALMOST_EMPTY, RX_FIFO_LEVEL} = {2'h3, 7'h06};
      clk(2);
      rd(7'h03);
      chk("evt", 8'h74, q);
      {TX_ALMOST_FULL, TX_ALMOST_EMPTY, RX_FIFO_LEVEL} = {2'h0, 7'h05};
      clk(2);
      rd(7'h03);
      chk("evt", 8'h04, q);
      pulse(TX_START);
      rd(7'h03);
      chk("evt", 8'h00, q);
      pulse(PKT_SENT);
      rd(7'h03);
      chk("evt", 8'h04, q);
      FIFO_MODE = 1'b0;
      clk(2);
      rd(7'h03);
      chk("evt", 8'h00, q);
      $display("test events done");
      summarize;
   end
endmodule // tb
`default_nettype wire
